// ### irq_prio_pkg.sv
// Package for the interrupt priority slice: register indices, field layouts, reset values.
// Assumes a 16-bit register port with word indices.
package irq_prio_pkg;
    localparam int unsigned DATA_W     = 16;
    localparam int unsigned ADDR_W     = 4;
    localparam int unsigned NUM_SRC    = 14;
    localparam int unsigned PRIO_W     = 3;
    // Register indices.
    localparam logic [3:0] REG_GLOBAL_CTRL  = 4'h0;
    localparam logic [3:0] REG_FLAG_STATUS  = 4'h1;
    localparam logic [3:0] REG_PRIO_SER_TMR = 4'h2;
    localparam logic [3:0] REG_PRIO_LOW     = 4'h3;
    localparam logic [3:0] REG_CPU_STATUS   = 4'h4;
    localparam logic [3:0] REG_CORE_CTRL    = 4'h5;
    localparam logic [3:0] REG_IRQ_STATUS   = 4'h6;
    localparam logic [3:0] REG_IRQ_MASK     = 4'h7;
    localparam logic [3:0] REG_DISABLE_CNT  = 4'h8;
    // Field positions.
    localparam int unsigned ALT_VEC_BIT     = 15;
    localparam int unsigned TOFF_BIT        = 14;
    localparam int unsigned EDGE_POL_LSB    = 0;
    localparam int unsigned SER_RX_PRIO_LSB = 12;
    localparam int unsigned SPI_EVT_PRIO_LSB = 8;
    localparam int unsigned SPI_ERR_PRIO_LSB = 4;
    localparam int unsigned TMR3_PRIO_LSB   = 0;
    localparam int unsigned CPU_PRIO_LSB    = 5;
    localparam int unsigned CORE_PRIO_BIT   = 3;
    // Source indices inside the flag register.
    localparam int unsigned SRC_SER_RX  = 11;
    localparam int unsigned SRC_SPI_EVT = 10;
    localparam int unsigned SRC_SPI_ERR = 9;
    localparam int unsigned SRC_TMR3    = 8;
    localparam logic [15:0] FLAG_IMPL_MASK  = 16'h3FEF;
    localparam logic [15:0] GCTRL_WR_MASK   = 16'h8007;
    localparam logic [15:0] PRIO_WR_MASK    = 16'h7777;
    localparam logic [15:0] PRIO_RESET      = 16'h4444;
    localparam logic [15:0] ZERO16          = 16'h0000;
    localparam logic [PRIO_W-1:0] PRIO_OFF  = 3'h0;
    localparam logic [1:0] EVT_NONE = 2'h0;
    localparam int unsigned EVT_ACCEPT = 0;
    localparam int unsigned EVT_TOFF_END = 1;

    typedef struct packed {
        logic              valid;
        logic [3:0]        level;
        logic [3:0]        source;
    } irq_req_t;
endpackage

// ### prio_select.sv
// Picks the highest priority pending source among sixteen flag bits.
// Assumes priorities arrive as one 3-bit field per source; ties go to the lower index.
`timescale 1ns/1ps
`default_nettype none
module prio_select #(
    parameter int unsigned N = 16
) (
    // Inputs
    input  wire logic [N-1:0]   pend_in,
    input  wire logic [3*N-1:0] prio_in,
    // Result
    output logic                found_out,
    output logic [2:0]          level_out,
    output logic [3:0]          index_out
);
    always_comb begin
        found_out = 1'b0;
        level_out = 3'h0;
        index_out = 4'h0;
        for (int i = 0; i < N; i++) begin
            // A zero field never wins: that source is disabled.
            if (pend_in[i] && prio_in[3*i +: 3] > level_out) begin
                found_out = 1'b1;
                level_out = prio_in[3*i +: 3];
                index_out = 4'(i);
            end
        end
    end
endmodule // prio_select
`default_nettype wire

// ### irq_prio_ctrl.sv
// Interrupt priority slice: flags, priority fields, global control, CPU level and request.
// Assumes peripherals pulse source events synchronous to mclk_in and the core
// acknowledges a presented request with a one-cycle pulse.
// Function
// - each source has a 3-bit priority; only sources 8-11 own theirs, the rest share low register fields; 001 is level 1, 111 is level 7.
// - a priority field of 000 disables the source; it never requests.
// - serial receiver priority sits in bits 14:12 of its priority register.
// - SPI transfer-event priority sits in bits 10:8 of that register.
// - CPU level is core priority bit above status bits 7:5.
// - global control bit 14 is read-only, 1 while timed disable is active.
`timescale 1ns/1ps
`default_nettype none
module irq_prio_ctrl
    import irq_prio_pkg::*;
#(
    parameter int unsigned CNT_W = 14
) (
    // Clock and reset
    input  wire logic                          mclk_in,
    input  wire logic                          rst_in,
    // Register port
    input  wire logic [irq_prio_pkg::ADDR_W-1:0] addr_in,
    input  wire logic [irq_prio_pkg::DATA_W-1:0] wdata_in,
    input  wire logic                          wr_in,
    input  wire logic                          rd_in,
    output logic [irq_prio_pkg::DATA_W-1:0]    rdata_out,
    // Peripheral events and external pins
    input  wire logic [15:0]                   src_event_in,
    input  wire logic [2:0]                    ext_irq_pin_in,
    // Core side
    input  wire logic                          toff_start_in,
    input  wire logic [CNT_W-1:0]              toff_count_in,
    input  wire logic                          ack_in,
    output irq_prio_pkg::irq_req_t             req_out,
    output logic [3:0]                         cpu_level_out,
    output logic                               alt_vector_out,
    output logic                               irq_out
);
    import irq_prio_pkg::*;

    logic [15:0]      gctrl_r, gctrl_nxt;
    logic [15:0]      flags_r, flags_nxt;
    logic [15:0]      prio_a_r, prio_a_nxt;
    logic [15:0]      prio_b_r, prio_b_nxt;
    logic [15:0]      status_r, status_nxt;
    logic [15:0]      core_r, core_nxt;
    logic [1:0]       evt_r, evt_nxt;
    logic [1:0]       emask_r, emask_nxt;
    logic [CNT_W-1:0] toff_cnt_r, toff_cnt_nxt;
    logic [2:0]       pin_q_r, pin_q_nxt;
    logic [15:0]      rdata_r, rdata_nxt;
    irq_req_t         req_r, req_nxt;
    logic [3:0]       lvl_r, lvl_nxt;
    logic             irq_r, irq_nxt;

    logic [15:0] ext_edge;
    logic [15:0] ev_all;
    logic [47:0] prio_vec;
    logic        found;
    logic [2:0]  best_lvl;
    logic [3:0]  best_idx;
    logic        toff_active;
    logic [3:0]  cpu_level;

    assign toff_active = (toff_cnt_r != '0);
    assign cpu_level   = {core_r[CORE_PRIO_BIT], status_r[CPU_PRIO_LSB +: 3]};

    // Edge detect on external pin 0 only, polarity from global control bit 0; bit 0 of flags.
    always_comb begin
        ext_edge = ZERO16;
        for (int i = 0; i < 3; i++) begin
            if (i == 0) begin
                ext_edge[0] = gctrl_r[EDGE_POL_LSB] ? (pin_q_r[0] & ~ext_irq_pin_in[0])
                                                    : (~pin_q_r[0] & ext_irq_pin_in[0]);
            end
        end
    end
    assign ev_all = (src_event_in | ext_edge) & FLAG_IMPL_MASK;

    // Map a priority field to every flag bit; unmapped sources use the low register.
    always_comb begin
        prio_vec = '0;
        prio_vec[3*SRC_SER_RX  +: 3] = prio_a_r[SER_RX_PRIO_LSB  +: 3];
        prio_vec[3*SRC_SPI_EVT +: 3] = prio_a_r[SPI_EVT_PRIO_LSB +: 3];
        prio_vec[3*SRC_SPI_ERR +: 3] = prio_a_r[SPI_ERR_PRIO_LSB +: 3];
        prio_vec[3*SRC_TMR3    +: 3] = prio_a_r[TMR3_PRIO_LSB    +: 3];
        for (int i = 0; i < 8; i++) begin
            prio_vec[3*i +: 3] = prio_b_r[4*(i/2) +: 3];
        end
        for (int i = 12; i < 16; i++) begin
            prio_vec[3*i +: 3] = prio_b_r[4*(i-12) +: 3];
        end
    end

    prio_select #(
        .N (16)
    ) u_sel (
        .pend_in   (flags_r),
        .prio_in   (prio_vec),
        .found_out (found),
        .level_out (best_lvl),
        .index_out (best_idx)
    );

    // Register writes and hardware updates.
    always_comb begin
        gctrl_nxt    = gctrl_r;
        flags_nxt    = flags_r;
        prio_a_nxt   = prio_a_r;
        prio_b_nxt   = prio_b_r;
        status_nxt   = status_r;
        core_nxt     = core_r;
        evt_nxt      = evt_r;
        emask_nxt    = emask_r;
        toff_cnt_nxt = toff_cnt_r;
        pin_q_nxt    = ext_irq_pin_in;
        if (toff_start_in) begin
            toff_cnt_nxt = toff_count_in;
        end else if (toff_active) begin
            toff_cnt_nxt = toff_cnt_r - 1'b1;
        end
        if (wr_in) begin
            unique case (addr_in)
                REG_GLOBAL_CTRL:  gctrl_nxt  = wdata_in & GCTRL_WR_MASK;
                REG_FLAG_STATUS:  flags_nxt  = flags_r & wdata_in;
                REG_PRIO_SER_TMR: prio_a_nxt = wdata_in & PRIO_WR_MASK;
                REG_PRIO_LOW:     prio_b_nxt = wdata_in & PRIO_WR_MASK;
                REG_CPU_STATUS:   status_nxt = wdata_in;
                REG_CORE_CTRL:    core_nxt   = wdata_in;
                REG_IRQ_STATUS:   evt_nxt    = evt_r & ~wdata_in[1:0];
                REG_IRQ_MASK:     emask_nxt  = wdata_in[1:0];
                default:          ;
            endcase
        end
        // Hardware sets win over a same-cycle software clear.
        flags_nxt = flags_nxt | ev_all;
        if (req_r.valid && ack_in) begin
            flags_nxt[req_r.source] = 1'b0;
            status_nxt[CPU_PRIO_LSB +: 3] = req_r.level[2:0];
            evt_nxt[EVT_ACCEPT] = 1'b1;
        end
        if (toff_cnt_r == CNT_W'(1) && !toff_start_in) begin
            evt_nxt[EVT_TOFF_END] = 1'b1;
        end
    end

    // Read data, request and outputs.
    always_comb begin
        rdata_nxt = ZERO16;
        if (rd_in) begin
            unique case (addr_in)
                REG_GLOBAL_CTRL: begin
                    rdata_nxt = gctrl_r;
                    rdata_nxt[TOFF_BIT] = toff_active;
                end
                REG_FLAG_STATUS:  rdata_nxt = flags_r;
                REG_PRIO_SER_TMR: rdata_nxt = prio_a_r;
                REG_PRIO_LOW:     rdata_nxt = prio_b_r;
                REG_CPU_STATUS:   rdata_nxt = status_r;
                REG_CORE_CTRL:    rdata_nxt = core_r;
                REG_IRQ_STATUS:   rdata_nxt = {14'h0000, evt_r};
                REG_IRQ_MASK:     rdata_nxt = {14'h0000, emask_r};
                REG_DISABLE_CNT:  rdata_nxt = 16'(toff_cnt_r);
                default:          rdata_nxt = ZERO16;
            endcase
        end
        // A request must beat the CPU level and waits out a timed disable.
        req_nxt.valid  = found && ({1'b0, best_lvl} > cpu_level) && !toff_active;
        req_nxt.level  = {1'b0, best_lvl};
        req_nxt.source = best_idx;
        if (req_r.valid && ack_in) begin
            req_nxt.valid = 1'b0;
        end
        lvl_nxt = cpu_level;
        irq_nxt = |(evt_nxt & emask_nxt);
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            gctrl_r    <= ZERO16;
            flags_r    <= ZERO16;
            prio_a_r   <= PRIO_RESET;
            prio_b_r   <= PRIO_RESET;
            status_r   <= ZERO16;
            core_r     <= ZERO16;
            evt_r      <= EVT_NONE;
            emask_r    <= EVT_NONE;
            toff_cnt_r <= '0;
            pin_q_r    <= 3'h0;
            rdata_r    <= ZERO16;
            req_r      <= '0;
            lvl_r      <= 4'h0;
            irq_r      <= 1'b0;
        end else begin
            gctrl_r    <= gctrl_nxt;
            flags_r    <= flags_nxt;
            prio_a_r   <= prio_a_nxt;
            prio_b_r   <= prio_b_nxt;
            status_r   <= status_nxt;
            core_r     <= core_nxt;
            evt_r      <= evt_nxt;
            emask_r    <= emask_nxt;
            toff_cnt_r <= toff_cnt_nxt;
            pin_q_r    <= pin_q_nxt;
            rdata_r    <= rdata_nxt;
            req_r      <= req_nxt;
            lvl_r      <= lvl_nxt;
            irq_r      <= irq_nxt;
        end
    end

    assign rdata_out      = rdata_r;
    assign req_out        = req_r;
    assign cpu_level_out  = lvl_r;
    assign alt_vector_out = gctrl_r[ALT_VEC_BIT];
    assign irq_out        = irq_r;

    // Assertions.
    sequence s_flag_event(int b);
        src_event_in[b] && FLAG_IMPL_MASK[b];
    endsequence

    a_disabled_never_req: assert property (@(posedge mclk_in) disable iff (rst_in)
        req_r.valid |-> prio_vec[3*req_r.source +: 3] != PRIO_OFF || $past(ack_in))
        else $error("request from a disabled source");
    a_req_level_match: assert property (@(posedge mclk_in) disable iff (rst_in)
        req_r.valid && !$past(ack_in) |-> req_r.level != 4'h0)
        else $error("request level zero");
    a_ser_field_used: assert property (@(posedge mclk_in) disable iff (rst_in)
        prio_vec[3*SRC_SER_RX +: 3] == prio_a_r[14:12])
        else $error("serial receiver priority field misplaced");
    a_spi_field_used: assert property (@(posedge mclk_in) disable iff (rst_in)
        prio_vec[3*SRC_SPI_EVT +: 3] == prio_a_r[10:8])
        else $error("SPI event priority field misplaced");
    a_cpu_level_out: assert property (@(posedge mclk_in) disable iff (rst_in)
        ##1 cpu_level_out == {$past(core_r[3]), $past(status_r[7:5])})
        else $error("CPU level not formed from core bit and status bits");
    a_toff_readback: assert property (@(posedge mclk_in) disable iff (rst_in)
        rd_in && addr_in == REG_GLOBAL_CTRL |=> rdata_out[14] == $past(toff_active))
        else $error("timed disable status bit wrong");
    a_flag_sets: assert property (@(posedge mclk_in) disable iff (rst_in)
        s_flag_event(11) |=> flags_r[11])
        else $error("flag not set by its event");
    a_flag_sticky: assert property (@(posedge mclk_in) disable iff (rst_in)
        flags_r[8] && !(wr_in && addr_in == REG_FLAG_STATUS && !wdata_in[8])
        && !(req_r.valid && ack_in && req_r.source == 4'h8) |=> flags_r[8])
        else $error("flag dropped without a clear");
endmodule // irq_prio_ctrl
`default_nettype wire

// ### core_ack_model.sv
// Core model: takes a presented request after a set delay with a one-cycle ack.
// Assumes req_in is the slice's registered request and hold_in stalls the core.
`timescale 1ns/1ps
`default_nettype none
module core_ack_model
    import irq_prio_pkg::*;
(
    // Clock and reset
    input  wire logic                   mclk_in,
    input  wire logic                   rst_in,
    // Control and request
    input  wire logic                   hold_in,
    input  wire logic [3:0]             delay_in,
    input  wire irq_prio_pkg::irq_req_t req_in,
    // Answer
    output logic                        ack_out,
    output logic [3:0]                  taken_out
);
    logic [3:0] wait_r;
    // A stalled core lets the request stand, which is how flags are seen to persist.
    always_ff @(posedge mclk_in) begin
        if (rst_in || !req_in.valid || hold_in || ack_out) begin
            wait_r  <= 4'h0;
            ack_out <= 1'b0;
        end else if (wait_r >= delay_in) begin
            ack_out   <= 1'b1;
            taken_out <= req_in.source;
        end else begin
            wait_r <= wait_r + 4'h1;
        end
    end
endmodule // core_ack_model
`default_nettype wire

// ### testbench.sv
// Bench for the interrupt priority slice: register port, events, core model.
// Assumes the core model answers requests and the bench owns all other inputs.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import irq_prio_pkg::*;
    logic        mclk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic [3:0]  addr_in = 4'h0;
    logic [15:0] wdata_in = 16'h0000;
    logic        wr_in = 1'b0;
    logic        rd_in = 1'b0;
    logic [15:0] src_event_in = 16'h0000;
    logic        toff_start_in = 1'b0;
    logic [13:0] toff_count_in = 14'h0000;
    logic        hold = 1'b1;
    logic [3:0]  dly = 4'h0;
    logic [15:0] rdata_out, d;
    irq_req_t    req_out;
    logic [3:0]  cpu_level_out, taken;
    logic        alt_vector_out, irq_out, ack;
    int          err_total = 0;
    int          n_compared = 0;
    int          cycles = 0;

    irq_prio_ctrl dut (.mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .src_event_in(src_event_in), .ext_irq_pin_in(3'h0),
        .toff_start_in(toff_start_in), .toff_count_in(toff_count_in), .ack_in(ack),
        .req_out(req_out), .cpu_level_out(cpu_level_out),
        .alt_vector_out(alt_vector_out), .irq_out(irq_out));
    core_ack_model core (.mclk_in(mclk_in), .rst_in(rst_in), .hold_in(hold),
        .delay_in(dly), .req_in(req_out), .ack_out(ack), .taken_out(taken));

    always #2.5 mclk_in = ~mclk_in;

    task automatic print_verdict();
        if (err_total == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            print_verdict();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
            err_total++;
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge mclk_in);
        addr_in <= a;
        wdata_in <= v;
        wr_in <= 1'b1;
        @(posedge mclk_in);
        wr_in <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge mclk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge mclk_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
    endtask

    // Pulses one source event, then leaves time for the request to form.
    task automatic ev(input int i);
        @(posedge mclk_in);
        src_event_in <= 16'h0001 << i;
        @(posedge mclk_in);
        src_event_in <= 16'h0000;
        repeat (3) @(posedge mclk_in);
        #1;
    endtask

    task automatic t_regs();
        rd(REG_PRIO_SER_TMR); chk(d, 16'h4444);
        rd(REG_GLOBAL_CTRL); chk(d, 16'h0000);
        rd(4'h9); chk(d, 16'h0000);
        wr(REG_PRIO_SER_TMR, 16'hFFFF); rd(REG_PRIO_SER_TMR); chk(d, 16'h7777);
    endtask

    task automatic t_flags();
        wr(REG_PRIO_SER_TMR, 16'h5000);
        ev(SRC_SER_RX); chk(16'(req_out), 16'h015B);
        wr(REG_FLAG_STATUS, 16'hFFFF); rd(REG_FLAG_STATUS); chk(d, 16'h0800);
        wr(REG_FLAG_STATUS, 16'h0000); rd(REG_FLAG_STATUS); chk(d, 16'h0000);
        chk(16'(req_out.valid), 16'h0000);
        wr(REG_PRIO_SER_TMR, 16'h0000);
        ev(SRC_SER_RX); ev(SRC_SPI_EVT); chk(16'(req_out.valid), 16'h0000);
        rd(REG_FLAG_STATUS); chk(d, 16'h0C00);
        wr(REG_PRIO_SER_TMR, 16'h0100); repeat (3) @(posedge mclk_in);
        #1 chk(16'(req_out), 16'h011A);
        wr(REG_FLAG_STATUS, 16'h0000);
    endtask

    task automatic t_level();
        wr(REG_CPU_STATUS, 16'h0040); wr(REG_CORE_CTRL, 16'h0008);
        wr(REG_PRIO_SER_TMR, 16'h7000);
        ev(SRC_SER_RX); chk(16'(cpu_level_out), 16'h000A);
        chk(16'(req_out.valid), 16'h0000);
        wr(REG_CORE_CTRL, 16'h0000); repeat (3) @(posedge mclk_in);
        #1 chk(16'(req_out), 16'h017B);
        wr(REG_FLAG_STATUS, 16'h0000); wr(REG_CPU_STATUS, 16'h0000);
    endtask

    task automatic t_ack(input logic [3:0] delay, input logic [15:0] mask);
        int k;
        dly <= delay; hold <= 1'b0;
        wr(REG_IRQ_MASK, mask); wr(REG_CPU_STATUS, 16'h0000);
        @(posedge mclk_in);
        src_event_in <= 16'h0800;
        @(posedge mclk_in);
        src_event_in <= 16'h0000;
        k = 0;
        while (ack !== 1'b1 && k < 20) begin
            @(posedge mclk_in); #1 k++;
        end
        chk(16'(ack), 16'h0001);
        chk(16'(taken), 16'h000B);
        repeat (3) @(posedge mclk_in);
        #1 chk(16'(cpu_level_out), 16'h0007);
        chk(16'(irq_out), mask);
        @(posedge mclk_in);
        hold <= 1'b1;
        rd(REG_FLAG_STATUS); chk(d, 16'h0000);
        wr(REG_IRQ_STATUS, 16'h0001); repeat (2) @(posedge mclk_in);
        #1 chk(16'(irq_out), 16'h0000);
    endtask

    task automatic t_timed_off();
        int k;
        wr(REG_CPU_STATUS, 16'h0000);
        @(posedge mclk_in);
        toff_start_in <= 1'b1;
        toff_count_in <= 14'h0014;
        @(posedge mclk_in);
        toff_start_in <= 1'b0;
        wr(REG_GLOBAL_CTRL, 16'hFFFF); rd(REG_GLOBAL_CTRL); chk(d, 16'hC007);
        chk(16'(alt_vector_out), 16'h0001);
        ev(SRC_SER_RX); chk(16'(req_out.valid), 16'h0000);
        k = 0;
        while (d[14] !== 1'b0 && k < 40) begin
            rd(REG_GLOBAL_CTRL); k++;
        end
        chk(d, 16'h8007);
        repeat (3) @(posedge mclk_in);
        #1 chk(16'(req_out), 16'h017B);
        wr(REG_FLAG_STATUS, 16'h0000); wr(REG_GLOBAL_CTRL, 16'h0000);
    endtask

    initial begin
        repeat (2) @(posedge mclk_in);
        rst_in <= 1'b0;
        t_regs();
        t_flags();
        t_level();
        t_ack(4'h0, 16'h0000);
        t_ack(4'h5, 16'h0001);
        t_timed_off();
        print_verdict();
    end
endmodule // testbench
`default_nettype wire
